// ---- hw/clc_cell.sv ----
`timescale 1ns/1ps
`include "clc_regs.svh"
module clc_cell #(
  parameter int CELL_IDX = 0
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire clc_pkg::clc_apb_req_t apb_req,
  output clc_pkg::clc_apb_rsp_t      apb_rsp,
  input  wire logic [39:0]           src_in,
  input  wire logic [2:0]            pin_in,
  output logic                       cell_output_signal,
  output logic                       irq
);
  import clc_pkg::*;

  clc_state_t s;
  clc_state_t next_s;
  logic [39:0] pool;
  logic [3:0]  d;
  logic [3:0]  g;
  logic        setup;
  logic        acc;
  logic        hit;
  logic [31:0] rd_val;
  logic        f;
  logic        rise1;
  logic        ev;

  // ==========================================================
  // Source pool
  // Pins replace their slots with the filtered copy, and the cell's own
  // slot is taken from its registered output so that feedback never loops.
  always_comb begin
    pool = src_in;
    pool[0] = 1'b0;
    for (int k = 0; k < `CLC_PIN_COUNT; k++) begin
      pool[int'(`CLC_SRC_PIN1) + k] = s.pin[k];
    end
    pool[int'(`CLC_SRC_CELL0) + CELL_IDX] = s.out;
  end

  // ==========================================================
  // Data selection and gating
  // four input muxes
  for (genvar i = 0; i < 4; i++) begin : g_mux
    assign d[i] = (s.sel[i] < `CLC_SRC_COUNT) ? pool[s.sel[i]] : 1'b0;
    assign g[i] = d[i] ^ s.gate_inv[i];
  end

  // ==========================================================
  // Bus decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc   = apb_req.psel & apb_req.penable;

  // Read value is captured in the setup cycle so prdata comes from a flop.
  always_comb begin
    rd_val = `CLC_RST_WORD;
    hit    = 1'b1;
    if (apb_req.paddr == `CLC_OFS_CTRL) begin
      rd_val[`CLC_BIT_EN]   = s.en;
      rd_val[`CLC_BIT_OUT]  = s.out;
      rd_val[`CLC_BIT_INTP] = s.intp;
      rd_val[`CLC_BIT_INTN] = s.intn;
      rd_val[2:0]           = s.mode;
    end else if (apb_req.paddr == `CLC_OFS_GATE) begin
      rd_val[`CLC_BIT_POL] = s.inv;
      rd_val[3:0]          = s.gate_inv;
    end else if (apb_req.paddr == `CLC_OFS_IRQ) begin
      rd_val[0] = s.irq;
    end else if (apb_req.paddr == `CLC_OFS_MASK) begin
      rd_val[0] = s.msk;
    end else begin
      hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (apb_req.paddr == `CLC_OFS_SEL0 + 12'(i) * `CLC_SEL_STRIDE) begin
          rd_val[5:0] = s.sel[i];
          hit         = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Next state
  assign rise1 = g[0] & ~s.g1_prev;
  assign ev = (s.intp & s.out & ~s.prev) | (s.intn & ~s.out & s.prev);

  always_comb begin
    next_s = s;
    // Three-stage pin filter; a change counts once stages two and three agree.
    next_s.p1 = pin_in;
    next_s.p2 = s.p1;
    next_s.p3 = s.p2;
    if (s.p2 == s.p3) begin
      next_s.pin = s.p3;
    end
    next_s.g1_prev = g[0];
    f = 1'b0;
    case (s.mode)
      CLC_AND_OR: f = (g[0] & g[1]) | (g[2] & g[3]);
      CLC_OR_XOR: f = (g[0] | g[1]) ^ (g[2] | g[3]);
      CLC_AND4:   f = &g;
      CLC_SR: begin
        if (g[0] | g[1]) begin
          next_s.q = 1'b1;
        end else if (g[2] | g[3]) begin
          next_s.q = 1'b0;
        end
        f = next_s.q;
      end
      CLC_DFF_SR: begin
        if (g[3]) begin
          next_s.q = 1'b1;
        end else if (g[2]) begin
          next_s.q = 1'b0;
        end else if (rise1) begin
          next_s.q = g[1];
        end
        f = next_s.q;
      end
      CLC_DFF_R: begin
        if (g[2]) begin
          next_s.q = 1'b0;
        end else if (rise1) begin
          next_s.q = g[1] ^ g[3];
        end
        f = next_s.q;
      end
      CLC_JK_R: begin
        if (g[2]) begin
          next_s.q = 1'b0;
        end else if (rise1 && (g[1] || g[3])) begin
          next_s.q = g[1] & g[3] ? ~s.q : g[1];
        end
        f = next_s.q;
      end
      default: begin
        if (g[3]) begin
          next_s.q = 1'b1;
        end else if (g[2]) begin
          next_s.q = 1'b0;
        end else if (g[0]) begin
          next_s.q = g[1];
        end
        f = next_s.q;
      end
    endcase
    next_s.out  = s.en & (f ^ s.inv);
    next_s.prev = s.out;
    // rising or falling edge flag
    // A new edge wins over a write-one clear in the same cycle.
    next_s.irq = s.irq | ev;
    if (setup) begin
      next_s.rdata = rd_val;
    end
    if (acc && apb_req.pwrite) begin
      if (apb_req.paddr == `CLC_OFS_CTRL) begin
        next_s.en   = apb_req.pwdata[`CLC_BIT_EN];
        next_s.intp = apb_req.pwdata[`CLC_BIT_INTP];
        next_s.intn = apb_req.pwdata[`CLC_BIT_INTN];
        next_s.mode = clc_mode_t'(apb_req.pwdata[2:0]);
      end else if (apb_req.paddr == `CLC_OFS_GATE) begin
        next_s.inv      = apb_req.pwdata[`CLC_BIT_POL];
        next_s.gate_inv = apb_req.pwdata[3:0];
      end else if (apb_req.paddr == `CLC_OFS_IRQ) begin
        next_s.irq = (s.irq & ~apb_req.pwdata[0]) | ev;
      end else if (apb_req.paddr == `CLC_OFS_MASK) begin
        next_s.msk = apb_req.pwdata[0];
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (apb_req.paddr == `CLC_OFS_SEL0 + 12'(i) * `CLC_SEL_STRIDE) begin
            next_s.sel[i] = apb_req.pwdata[5:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // The slave never waits, so every access phase completes in one cycle.
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = s.rdata;
  assign apb_rsp.pslverr = acc & ~hit;
  assign cell_output_signal = s.out;
  assign irq = s.irq & s.msk;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  dis_zero_a: assert property (!s.en |=> !cell_output_signal)
    else $error("disabled cell drove a one");
  out_mirror_a: assert property (setup && apb_req.paddr == `CLC_OFS_CTRL ##1 acc
    |-> apb_rsp.prdata[`CLC_BIT_OUT] == $past(s.out))
    else $error("output bit does not mirror the cell");
  rise_flag_a: assert property (s.intp && s.out && !s.prev |=> s.irq)
    else $error("rising edge did not set the flag");
  fall_flag_a: assert property (s.intn && !s.out && s.prev |=> s.irq)
    else $error("falling edge did not set the flag");
  flag_cause_a: assert property ($rose(s.irq) |-> $past(ev))
    else $error("flag set without an enabled edge");
  and4_func_a: assert property (s.en && s.mode == CLC_AND4
    |=> s.out == ($past(&g) ^ $past(s.inv)))
    else $error("four-input AND gave a wrong output");
  sel_write_a: assert property (acc && apb_req.pwrite && apb_req.paddr == `CLC_OFS_SEL0
    |=> s.sel[0] == $past(apb_req.pwdata[5:0]))
    else $error("select write not stored");
  resv_code_a: assert property (s.sel[1] >= `CLC_SRC_COUNT |-> !d[1])
    else $error("reserved code passed a signal");
  dffr_reset_a: assert property (s.mode == CLC_DFF_R && g[2] ##1 s.mode == CLC_DFF_R
    |-> !s.q)
    else $error("D flip-flop reset ignored");
  pin_agree_a: assert property (s.pin != $past(s.pin) |-> $past(s.p2 == s.p3))
    else $error("pin changed before stages agreed");
  irq_cov_c: cover property (s.intp && s.out && !s.prev ##1 irq);
  jk_cov_c: cover property (s.en && s.mode == CLC_JK_R && rise1);
  err_cov_c: cover property (apb_rsp.pslverr);
endmodule : clc_cell

// ---- hw/clc_pkg.sv ----
package clc_pkg;
  typedef enum logic [2:0] {
    CLC_AND_OR = 3'b000,
    CLC_OR_XOR = 3'b001,
    CLC_AND4   = 3'b010,
    CLC_SR     = 3'b011,
    CLC_DFF_SR = 3'b100,
    CLC_DFF_R  = 3'b101,
    CLC_JK_R   = 3'b110,
    CLC_LATCH  = 3'b111
  } clc_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } clc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } clc_apb_rsp_t;

  typedef struct packed {
    logic            en;
    logic            intp;
    logic            intn;
    clc_mode_t       mode;
    logic            inv;
    logic [3:0]      gate_inv;
    logic [3:0][5:0] sel;
    logic            q;
    logic            out;
    logic            prev;
    logic            g1_prev;
    logic            irq;
    logic            msk;
    logic [2:0]      p1;
    logic [2:0]      p2;
    logic [2:0]      p3;
    logic [2:0]      pin;
    logic [31:0]     rdata;
  } clc_state_t;
endpackage : clc_pkg

// ---- hw/clc_regs.svh ----
`ifndef CLC_REGS_SVH
`define CLC_REGS_SVH
// Functional notes
// - Select, gate, function, polarity stages in order.
// - Software may rewrite configuration at any time.
// - Four muxes each pick from 40 sources.
// - Code 39 wave, 26-29 cells, 1-3 pins.
// - Each mux has its own select register.
// - Enable clear forces cell output to zero.
// - Read-only output bit mirrors polarity stage output.
// - Rising edge sets flag when enabled.
// - Falling edge sets flag when enabled.
// - Codes 100-111 select the sequential cells.
// - Codes 000-011 select AND-OR, OR-XOR, AND4, SR.

// ==========================================================
// Register byte offsets
`define CLC_OFS_CTRL   12'h000
`define CLC_OFS_SEL0   12'h004
`define CLC_SEL_STRIDE 12'h004
`define CLC_OFS_GATE   12'h014
`define CLC_OFS_IRQ    12'h018
`define CLC_OFS_MASK   12'h01C

// ==========================================================
// Field positions
`define CLC_BIT_EN    7
`define CLC_BIT_OUT   5
`define CLC_BIT_INTP  4
`define CLC_BIT_INTN  3
`define CLC_BIT_POL   7

// ==========================================================
// Source codes and reset values
`define CLC_SRC_COUNT 6'h28
`define CLC_SRC_PIN1  6'h01
`define CLC_SRC_CELL0 6'h1A
`define CLC_PIN_COUNT 3
`define CLC_RST_WORD  32'h0000_0000
`endif

// ---- testbench/clc_cell_tb.sv ----
`timescale 1ns/1ps
`include "clc_regs.svh"
module clc_cell_tb;
  import clc_pkg::*;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  clc_apb_req_t req = '0;
  clc_apb_rsp_t rsp;
  logic [39:0]  want = '0;
  logic [2:0]   wpin = '0;
  logic [39:0]  src;
  logic [2:0]   pin;
  logic         out;
  logic         irq;
  logic [31:0]  q;
  logic         e;
  logic [3:0]   g;
  int           failures = 0;
  int           checks = 0;
  int           cyc = 0;
  int           codes [3] = '{39, 27, 1};
  // Each entry is function code, pattern of g3..g0, expected output.
  logic [7:0]   seq [12] = '{8'h63, 8'h68, 8'h91, 8'h88, 8'hF1, 8'hE8,
                             8'hA8, 8'hA4, 8'hA7, 8'hC8, 8'hC4, 8'hC7};

  clc_src_model model (.clk(clk), .srst(srst), .want_src(want), .want_pin(wpin),
                       .src_in(src), .pin_in(pin));
  clc_cell #(.CELL_IDX(0)) dut (.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
                                .src_in(src), .pin_in(pin), .cell_output_signal(out),
                                .irq(irq));

  // ==========================================================
  // Clock and hang guard
  always #12.5 clk = ~clk;
  // A stuck handshake must not hang the run, so it ends in the report instead.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus and check tasks
  // One APB transfer; request held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h00_0000, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // Writes wait a little so the outputs have settled before anything is sampled.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    tick(3);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(n, {24'h00_0000, x}, q);
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd("ctrl_reset", `CLC_OFS_CTRL, 8'h00);
    rd("irq_reset", `CLC_OFS_IRQ, 8'h00);
    apb(1'b0, 12'h020, 8'h00);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, q);
    for (int i = 0; i < 4; i++) wr(12'(`CLC_OFS_SEL0 + `CLC_SEL_STRIDE * i), 8'(4 + i));
    rd("sel2", 12'h00C, 8'h06);
    wr(`CLC_OFS_MASK, 8'h01);
    // Every gated pattern through the three plain gate functions.
    for (int m = 0; m < 3; m++) begin
      wr(`CLC_OFS_CTRL, 8'(8'h80 + m));
      for (int p = 0; p < 16; p++) begin
        g = 4'(p);
        want[7:4] <= g;
        tick(5);
        chk("comb", m == 0 ? 32'((g[0] & g[1]) | (g[2] & g[3])) :
                    m == 1 ? 32'((g[0] | g[1]) ^ (g[2] | g[3])) : 32'(&g), out);
      end
    end
    // Edge flags, both polarities, enable and mask.
    wr(`CLC_OFS_CTRL, 8'h92);
    want[7:4] <= 4'h0;
    tick(5);
    wr(`CLC_OFS_IRQ, 8'h01);
    chk("irq_clear", 0, irq);
    want[7:4] <= 4'hF;
    tick(5);
    chk("irq_rise", 1, irq);
    rd("out_bit", `CLC_OFS_CTRL, 8'hB2);
    wr(`CLC_OFS_IRQ, 8'h01);
    want[7:4] <= 4'h0;
    tick(5);
    chk("fall_off", 0, irq);
    wr(`CLC_OFS_CTRL, 8'h8A);
    want[7:4] <= 4'hF;
    tick(5);
    chk("rise_off", 0, irq);
    want[7:4] <= 4'h0;
    tick(5);
    chk("irq_fall", 1, irq);
    rd("irq_status", `CLC_OFS_IRQ, 8'h01);
    wr(`CLC_OFS_MASK, 8'h00);
    chk("irq_masked", 0, irq);
    wr(`CLC_OFS_MASK, 8'h01);
    wr(`CLC_OFS_IRQ, 8'h01);
    chk("irq_w1c", 0, irq);
    // Polarity, gate inversion and disable.
    wr(`CLC_OFS_GATE, 8'h80);
    chk("out_invert", 1, out);
    wr(`CLC_OFS_CTRL, 8'h02);
    chk("disabled", 0, out);
    wr(`CLC_OFS_CTRL, 8'h82);
    wr(`CLC_OFS_GATE, 8'h0F);
    chk("gate_invert", 1, out);
    wr(`CLC_OFS_GATE, 8'h00);
    // Wave source, another cell and a pin, then a reserved code.
    foreach (codes[k]) begin
      wr(`CLC_OFS_SEL0, 8'(codes[k]));
      want <= '1;
      wpin <= 3'h7;
      tick(10);
      chk("src_high", 1, out);
      if (codes[k] == 1) wpin <= 3'h6;
      else want[codes[k]] <= 1'b0;
      tick(10);
      chk("src_low", 0, out);
    end
    wr(`CLC_OFS_SEL0, 8'h28);
    want <= '1;
    tick(5);
    chk("reserved", 0, out);
    wr(`CLC_OFS_SEL0, 8'h04);
    want <= '0;
    // Latch and flip-flop functions stepped through a fixed table.
    foreach (seq[k]) begin
      wr(`CLC_OFS_CTRL, {5'b10000, seq[k][7:5]});
      want[7:4] <= seq[k][4:1];
      tick(5);
      chk("seq", 32'(seq[k][0]), out);
    end
    tally_and_finish();
  end
endmodule : clc_cell_tb

// ---- testbench/clc_src_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Source pool stand-in
// Models the peripherals and pins feeding the cell; outputs move only after an edge.
module clc_src_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [39:0] want_src,
  input  wire logic [2:0]  want_pin,
  output logic      [39:0] src_in,
  output logic      [2:0]  pin_in
);
  // Registered so the cell never sees a source change in the edge that set it.
  always_ff @(posedge clk) begin
    src_in <= srst ? 40'h00_0000_0000 : want_src;
    pin_in <= want_pin;
  end
endmodule : clc_src_model
